// [verilog/fpcc_regs.svh]
`ifndef FPCC_REGS_SVH
`define FPCC_REGS_SVH
// ==========================================================

// ==========================================================
// Register offsets (byte addresses)
`define FPCC_ADDR_W          12
`define FPCC_CSR_OFF         12'h000
`define FPCC_CC_OFF          12'h004
`define FPCC_IRQ_STAT_OFF    12'h008
`define FPCC_IRQ_MASK_OFF    12'h00c

// ==========================================================
// Field positions
`define FPCC_CSR_INV_EN_BIT   0
`define FPCC_CSR_INV_FLAG_BIT 1
`define FPCC_EV_INV_BIT       0
`define FPCC_EV_EXC_BIT       1
`define FPCC_EV_DONE_BIT      2
`define FPCC_EV_W             3
`define FPCC_CC_W             8
`define FPCC_SEL_EXT_BIT      3

// ==========================================================
// Reset values
`define FPCC_CC_RST          8'h00
`define FPCC_EV_RST          3'h0
`define FPCC_RDATA_RST       32'h0000_0000
`endif

// [verilog/fpcc_pkg.sv]
package fpcc_pkg;
    typedef enum logic [1:0] {
        FPCC_FMT_SINGLE = 2'b00,
        FPCC_FMT_DOUBLE = 2'b01,
        FPCC_FMT_PAIRED = 2'b10
    } fpcc_fmt_t;

    typedef struct packed {
        logic [7:0]  cc;
        logic        inv_en;
        logic        inv_flag;
        logic [2:0]  irq_stat;
        logic [2:0]  irq_mask;
        logic [31:0] prdata;
        logic        cmp_done;
        logic        inv_exc;
    } fpcc_state_t;
endpackage : fpcc_pkg

// [verilog/fpcc_rel.sv]
`timescale 1ns/1ps
module fpcc_rel (
    // Operands
    input  wire logic [63:0] op_a,
    input  wire logic [63:0] op_b,
    input  wire logic        is_double,
    // Ordering relations
    output logic             rel_gt,
    output logic             rel_lt,
    output logic             rel_eq,
    output logic             rel_un,
    // NaN classes
    output logic             any_snan,
    output logic             any_qnan
);
    // {is_nan, is_quiet}; quiet when the top mantissa bit is set
    function automatic logic [1:0] nan_kind(input logic [63:0] v, input logic dbl);
        logic nan;
        logic quiet;
        nan   = dbl ? (&v[62:52] && |v[51:0]) : (&v[30:23] && |v[22:0]);
        quiet = dbl ? v[51] : v[22];
        return {nan, nan & quiet};
    endfunction : nan_kind

    logic [62:0] mag_a;
    logic [62:0] mag_b;
    logic        sgn_a;
    logic        sgn_b;
    logic [1:0]  kind_a;
    logic [1:0]  kind_b;
    logic        both_zero;
    logic        mag_gt;

    // Sign-magnitude compare is exact: no arithmetic, so no overflow
    assign mag_a     = is_double ? op_a[62:0] : {32'h0000_0000, op_a[30:0]};
    assign mag_b     = is_double ? op_b[62:0] : {32'h0000_0000, op_b[30:0]};
    assign sgn_a     = is_double ? op_a[63] : op_a[31];
    assign sgn_b     = is_double ? op_b[63] : op_b[31];
    assign kind_a    = nan_kind(op_a, is_double);
    assign kind_b    = nan_kind(op_b, is_double);
    assign both_zero = (mag_a == 63'h0) && (mag_b == 63'h0);
    assign mag_gt    = mag_a > mag_b;

    assign any_snan = (kind_a[1] & ~kind_a[0]) | (kind_b[1] & ~kind_b[0]);
    assign any_qnan = kind_a[0] | kind_b[0];

    always_comb begin
        rel_gt = 1'b0;
        rel_lt = 1'b0;
        rel_eq = 1'b0;
        rel_un = 1'b0;
        if (kind_a[1] || kind_b[1]) begin
            rel_un = 1'b1;
        end else if (both_zero || (sgn_a == sgn_b && mag_a == mag_b)) begin
            rel_eq = 1'b1;
        end else if (sgn_a != sgn_b) begin
            rel_lt = sgn_a;
            rel_gt = ~sgn_a;
        end else begin
            rel_gt = mag_gt ^ sgn_a;
            rel_lt = ~(mag_gt ^ sgn_a);
        end
    end
endmodule : fpcc_rel

// [verilog/fpcc_unit.sv]
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "fpcc_regs.svh"
module fpcc_unit
    import fpcc_pkg::*;
(
    // Clock, reset, enable
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic                    clk_en,
    // APB slave
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [`FPCC_ADDR_W-1:0] paddr,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    // Compare issue from the pipeline
    input  wire logic                    cmp_valid,
    input  wire fpcc_fmt_t               operand_format,
    input  wire logic [3:0]              predicate_select,
    input  wire logic [2:0]              cond_code_index,
    input  wire logic [63:0]             first_source_reg,
    input  wire logic [63:0]             second_source_reg,
    // Results
    output logic                         cmp_done,
    output logic                         inv_exc,
    output logic      [7:0]              cond_codes,
    output logic                         irq
);

    // ==========================================================
    // Functions

    // {hit, index}; unmapped offsets answer with pslverr
    function automatic logic [2:0] reg_decode(input logic [`FPCC_ADDR_W-1:0] a);
        logic [2:0] r;
        r = 3'h0;
        case (a)
            `FPCC_CSR_OFF:      r = 3'h4;
            `FPCC_CC_OFF:       r = 3'h5;
            `FPCC_IRQ_STAT_OFF: r = 3'h6;
            `FPCC_IRQ_MASK_OFF: r = 3'h7;
            default:            r = 3'h0;
        endcase
        return r;
    endfunction : reg_decode

    // OR of the selected relations; greater never enters
    function automatic logic pred_eval(
        input logic [2:0] cond,
        input logic       lt,
        input logic       eq,
        input logic       un
    );
        return (cond[0] & un) | (cond[1] & eq) | (cond[2] & lt);
    endfunction : pred_eval

    // ==========================================================
    // State

    fpcc_state_t st;
    fpcc_state_t next_st;

    // ==========================================================
    // Relation units: half 0 is the whole operand or low single,
    // half 1 is the upper single of a paired operand

    logic [1:0] rel_gt;
    logic [1:0] rel_lt;
    logic [1:0] rel_eq;
    logic [1:0] rel_un;
    logic [1:0] half_snan;
    logic [1:0] half_qnan;

    genvar h;
    generate
        for (h = 0; h < 2; h++) begin : g_half
            logic [63:0] a_in;
            logic [63:0] b_in;
            logic        dbl;
            if (h == 0) begin : g_low
                assign a_in = first_source_reg;
                assign b_in = second_source_reg;
                assign dbl  = (operand_format == FPCC_FMT_DOUBLE);
            end else begin : g_high
                assign a_in = {32'h0000_0000, first_source_reg[63:32]};
                assign b_in = {32'h0000_0000, second_source_reg[63:32]};
                assign dbl  = 1'b0;
            end
            fpcc_rel u_rel (
                .op_a      (a_in),
                .op_b      (b_in),
                .is_double (dbl),
                .rel_gt    (rel_gt[h]),
                .rel_lt    (rel_lt[h]),
                .rel_eq    (rel_eq[h]),
                .rel_un    (rel_un[h]),
                .any_snan  (half_snan[h]),
                .any_qnan  (half_qnan[h])
            );
        end
    endgenerate

    // ==========================================================
    // Compare evaluation

    logic       is_paired;
    logic       snan_seen;
    logic       nan_seen;
    logic       inv_raise;
    logic       take_exc;
    logic       res_lo;
    logic       res_hi;
    logic [2:0] idx_lo;
    logic [2:0] idx_hi;

    assign is_paired = (operand_format == FPCC_FMT_PAIRED);
    // Upper half counts only for paired operands
    assign snan_seen = half_snan[0] | (is_paired & half_snan[1]);
    assign nan_seen  = rel_un[0] | (is_paired & rel_un[1]);

    // Quiet NaN raises only in the extended set
    assign inv_raise = cmp_valid
                     & (snan_seen | (predicate_select[`FPCC_SEL_EXT_BIT] & nan_seen));
    assign take_exc  = inv_raise & st.inv_en;

    // Same eight conditions in both sets
    assign res_lo = pred_eval(predicate_select[2:0], rel_lt[0], rel_eq[0], rel_un[0]);
    assign res_hi = pred_eval(predicate_select[2:0], rel_lt[1], rel_eq[1], rel_un[1]);

    // An odd index makes both halves write the same bit, the upper result winning; software must not rely on it
    assign idx_lo = cond_code_index;
    assign idx_hi = {cond_code_index[2:1], 1'b1};

    // ==========================================================
    // APB decode

    logic [2:0] dec;
    logic       acc;
    logic       wr;
    logic       setup_rd;

    assign dec      = reg_decode(paddr);
    assign acc      = psel & penable;
    assign wr       = acc & pwrite & dec[2];
    assign setup_rd = psel & ~penable & ~pwrite;

    // Read data is captured in setup, so the access phase never waits
    assign pready  = 1'b1;
    assign pslverr = acc & ~dec[2];

    // ==========================================================
    // Next state

    logic [`FPCC_EV_W-1:0] ev;
    logic [31:0]           rd_val;

    always_comb begin
        next_st          = st;
        next_st.cmp_done = 1'b0;
        next_st.inv_exc  = 1'b0;
        ev               = `FPCC_EV_RST;
        rd_val           = `FPCC_RDATA_RST;

        // Result write; an exception leaves all codes as they were
        if (cmp_valid && !take_exc) begin
            next_st.cc[idx_lo] = res_lo;
            if (is_paired) begin
                next_st.cc[idx_hi] = res_hi;
            end
        end
        next_st.cmp_done = cmp_valid & ~take_exc;
        next_st.inv_exc  = take_exc;

        // Register writes
        if (wr) begin
            case (dec[1:0])
                2'h0: begin
                    next_st.inv_en = pwdata[`FPCC_CSR_INV_EN_BIT];
                    if (pwdata[`FPCC_CSR_INV_FLAG_BIT]) begin
                        next_st.inv_flag = 1'b0;
                    end
                end
                2'h2: begin
                    next_st.irq_stat = st.irq_stat & ~pwdata[`FPCC_EV_W-1:0];
                end
                2'h3: begin
                    next_st.irq_mask = pwdata[`FPCC_EV_W-1:0];
                end
                default: begin
                end
            endcase
        end

        // Hardware sets after software clears, so a same-cycle event wins
        if (inv_raise) begin
            next_st.inv_flag = 1'b1;
        end
        ev[`FPCC_EV_INV_BIT]  = inv_raise;
        ev[`FPCC_EV_EXC_BIT]  = take_exc;
        ev[`FPCC_EV_DONE_BIT] = cmp_valid & ~take_exc;
        next_st.irq_stat      = next_st.irq_stat | ev;

        // Read data capture
        case (dec)
            3'h4: begin
                rd_val[`FPCC_CSR_INV_EN_BIT]   = st.inv_en;
                rd_val[`FPCC_CSR_INV_FLAG_BIT] = st.inv_flag;
            end
            3'h5:    rd_val[`FPCC_CC_W-1:0] = st.cc;
            3'h6:    rd_val[`FPCC_EV_W-1:0] = st.irq_stat;
            3'h7:    rd_val[`FPCC_EV_W-1:0] = st.irq_mask;
            default: rd_val = `FPCC_RDATA_RST;
        endcase
        if (setup_rd) begin
            next_st.prdata = rd_val;
        end
    end

    // ==========================================================
    // State register

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st.cc       <= `FPCC_CC_RST;
            st.inv_en   <= 1'b0;
            st.inv_flag <= 1'b0;
            st.irq_stat <= `FPCC_EV_RST;
            st.irq_mask <= `FPCC_EV_RST;
            st.prdata   <= `FPCC_RDATA_RST;
            st.cmp_done <= 1'b0;
            st.inv_exc  <= 1'b0;
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    // ==========================================================
    // Outputs

    assign prdata     = st.prdata;
    assign cmp_done   = st.cmp_done;
    assign inv_exc    = st.inv_exc;
    assign cond_codes = st.cc;
    assign irq        = |(st.irq_stat & st.irq_mask);

endmodule : fpcc_unit

// [test/fpcc_props.sv]
`timescale 1ns/1ps
// ==========================================
// Compare unit checker
module fpcc_props
    import fpcc_pkg::*;
(
    // Clocking
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        clk_en,
    // Register bus and interrupt
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        irq,
    // Compare side
    input wire logic        cmp_valid,
    input wire fpcc_fmt_t   operand_format,
    input wire logic [3:0]  predicate_select,
    input wire logic [2:0]  cond_code_index,
    input wire logic [63:0] first_source_reg,
    input wire logic [63:0] second_source_reg,
    input wire logic        cmp_done,
    input wire logic        inv_exc,
    input wire logic [7:0]  cond_codes
);
    logic sgl;
    assign sgl = cmp_valid && clk_en && operand_format == FPCC_FMT_SINGLE;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_one_answer: assert property (cmp_valid && clk_en |=> cmp_done != inv_exc)
        else $error("compare gave no single answer");
    a_no_answer: assert property (clk_en && !cmp_valid |=> !cmp_done && !inv_exc)
        else $error("answer without a compare");
    a_exc_holds: assert property (inv_exc |-> $stable(cond_codes))
        else $error("codes changed on exception");
    a_one_bit: assert property (sgl |=> cmp_done |-> ((cond_codes ^ $past(cond_codes))
        & ~(8'h01 << $past(cond_code_index))) == 8'h00) else $error("other code bit changed");
    a_false_code: assert property (sgl && predicate_select[2:0] == 3'h0
        |=> cmp_done |-> !cond_codes[$past(cond_code_index)]) else $error("false was true");
    a_same_bits: assert property (sgl && predicate_select[2:0] == 3'h2
        && first_source_reg[31:0] == second_source_reg[31:0] && first_source_reg[30:23] != 8'hff
        |=> cmp_done |-> cond_codes[$past(cond_code_index)]) else $error("equal not seen");
    a_zero_sign: assert property (sgl && predicate_select[2:0] == 3'h6
        && first_source_reg[31:0] == 32'h0 && second_source_reg[31:0] == 32'h8000_0000
        |=> cmp_done |-> cond_codes[$past(cond_code_index)]) else $error("zeros differ");
    a_qnan_quiet: assert property (sgl && !predicate_select[3]
        && first_source_reg[30:22] == 9'h1ff && second_source_reg[30:23] != 8'hff
        |=> cmp_done) else $error("quiet nan raised invalid");
    c_done: cover property (cmp_done);
    c_exc: cover property (inv_exc);
    c_irq: cover property (irq);
endmodule : fpcc_props
bind fpcc_unit fpcc_props fpcc_props_i (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite,
    .pready, .pslverr, .irq, .paddr, .pwdata, .prdata, .cmp_valid, .cmp_done, .inv_exc,
    .operand_format, .predicate_select, .cond_code_index, .first_source_reg,
    .second_source_reg, .cond_codes);

// [test/fpcc_pipe_model.sv]
`timescale 1ns/1ps
// ==========================================
// Pipeline issuing compares
module fpcc_pipe_model
    import fpcc_pkg::*;
(
    // Clock
    input  wire logic   pclk,
    // Compare issue
    output logic        cmp_valid,
    output fpcc_fmt_t   operand_format,
    output logic [3:0]  predicate_select,
    output logic [2:0]  cond_code_index,
    output logic [63:0] first_source_reg,
    output logic [63:0] second_source_reg
);
    initial begin
        cmp_valid = 1'b0;
        operand_format = FPCC_FMT_SINGLE;
        predicate_select = 4'h0;
        cond_code_index = 3'h0;
        first_source_reg = 64'h0;
        second_source_reg = 64'h0;
    end
    task automatic issue(input fpcc_fmt_t f, input logic [3:0] s, input logic [2:0] i,
                         input logic [63:0] a, input logic [63:0] b);
        @(posedge pclk);
        cmp_valid <= 1'b1;
        operand_format <= f;
        predicate_select <= s;
        cond_code_index <= (f == FPCC_FMT_PAIRED) ? {i[2:1], 1'b0} : i;
        first_source_reg <= a;
        second_source_reg <= b;
        @(posedge pclk);
        cmp_valid <= 1'b0;
        // Stale operands must not look valid
        first_source_reg <= ~a;
        second_source_reg <= ~b;
    endtask : issue
endmodule : fpcc_pipe_model

// [test/testbench.sv]
`timescale 1ns/1ps
`include "fpcc_regs.svh"
module testbench;
    import fpcc_pkg::*;
    logic        pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, irq;
    logic        cmp_valid, cmp_done, inv_exc, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    fpcc_fmt_t   operand_format;
    logic [3:0]  predicate_select;
    logic [2:0]  cond_code_index;
    logic [63:0] first_source_reg, second_source_reg;
    logic [7:0]  cond_codes;
    int          fail_count, tests_run, cycles;
    fpcc_unit fpcc_unit_i (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .cmp_valid, .operand_format, .predicate_select,
        .cond_code_index, .first_source_reg, .second_source_reg, .cmp_done, .inv_exc,
        .cond_codes, .irq);
    fpcc_pipe_model fpcc_pipe_model_i (.pclk, .cmp_valid, .operand_format, .predicate_select,
        .cond_code_index, .first_source_reg, .second_source_reg);
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // ==========================================
    // Shared tasks
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic end_sim;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_sim
    // ==========================================
    // Scenarios
    // Enable low must swallow a compare whole
    task automatic t_freeze;
        @(posedge pclk);
        clk_en <= 1'b0;
        fpcc_pipe_model_i.issue(FPCC_FMT_SINGLE, 4'h4, 3'h0, 64'h3f80_0000, 64'h4000_0000);
        #1;
        chk("frozen done", 0, cmp_done);
        chk("frozen code", 0, cond_codes[0]);
        @(posedge pclk);
        clk_en <= 1'b1;
        $display("test freeze done");
    endtask : t_freeze
    task automatic t_preds;
        logic [31:0] a [5] = '{32'h3f80_0000, 32'h4000_0000, 32'h0, 32'h7fc0_0000, 32'h3f80_0000};
        logic [31:0] b [5] = '{32'h4000_0000, 32'h3f80_0000, 32'h8000_0000, 32'h7fc0_0000,
                               32'h3f80_0000};
        logic [2:0]  rl [5] = '{3'b100, 3'b000, 3'b010, 3'b001, 3'b010};
        for (int r = 0; r < 5; r++)
            for (int c = 0; c < 8; c++) begin
                fpcc_pipe_model_i.issue(FPCC_FMT_SINGLE, c[3:0], c[2:0], {32'h0, a[r]},
                                        {32'h0, b[r]});
                #1;
                chk("done", 1, cmp_done);
                chk("code", (c[0] & rl[r][0]) | (c[1] & rl[r][1]) | (c[2] & rl[r][2]),
                    cond_codes[c]);
            end
        fpcc_pipe_model_i.issue(FPCC_FMT_DOUBLE, 4'h4, 3'h1, 64'hbff0_0000_0000_0000,
                                64'h3ff0_0000_0000_0000);
        #1;
        chk("double", 1, cond_codes[1]);
        $display("test preds done");
    endtask : t_preds
    task automatic t_paired;
        fpcc_pipe_model_i.issue(FPCC_FMT_PAIRED, 4'h4, 3'h5, 64'h3f80_0000_4000_0000,
                                64'h4000_0000_3f80_0000);
        #1;
        chk("paired hi", 2'b10, cond_codes[5:4]);
        fpcc_pipe_model_i.issue(FPCC_FMT_PAIRED, 4'h4, 3'h4, 64'h4000_0000_3f80_0000,
                                64'h3f80_0000_4000_0000);
        #1;
        chk("paired lo", 2'b01, cond_codes[5:4]);
        $display("test paired done");
    endtask : t_paired
    task automatic t_inv;
        // Codes left by the earlier scenarios; only result events so far
        logic [31:0] rd_exp [4] = '{32'h0, 32'hde, 32'h4, 32'h0};
        for (int r = 0; r < 4; r++) begin
            apb(1'b0, 12'(r * 4), 32'h0);
            chk("reg", rd_exp[r], q);
        end
        apb(1'b1, `FPCC_IRQ_MASK_OFF, 32'h1);
        fpcc_pipe_model_i.issue(FPCC_FMT_SINGLE, 4'h9, 3'h6, 64'h7fc0_0000, 64'h3f80_0000);
        #1;
        chk("ext done", 1, cmp_done);
        chk("ext code", 1, cond_codes[6]);
        apb(1'b0, `FPCC_CSR_OFF, 32'h0);
        chk("flag", 32'h2, q);
        chk("irq set", 1, irq);
        apb(1'b1, `FPCC_IRQ_STAT_OFF, 32'h7);
        #1;
        chk("irq clr", 0, irq);
        apb(1'b1, `FPCC_CSR_OFF, 32'h3);
        fpcc_pipe_model_i.issue(FPCC_FMT_SINGLE, 4'h0, 3'h6, 64'h7f80_0001, 64'h3f80_0000);
        #1;
        chk("exc", 1, inv_exc);
        chk("kept", 1, cond_codes[6]);
        // Quiet NaN in the plain set writes even with the enable on
        fpcc_pipe_model_i.issue(FPCC_FMT_SINGLE, 4'h1, 3'h5, 64'h7fc0_0000, 64'h3f80_0000);
        #1;
        chk("quiet done", 1, cmp_done);
        chk("quiet code", 1, cond_codes[5]);
        apb(1'b0, `FPCC_CSR_OFF, 32'h0);
        chk("csr", 32'h3, q);
        apb(1'b0, 12'h010, 32'h0);
        chk("slverr", 1, e);
        $display("test invalid done");
    endtask : t_inv
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fail_count++;
            end_sim();
        end
    end
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        clk_en = 1'b1;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_freeze();
        t_preds();
        t_paired();
        t_inv();
        end_sim();
    end
endmodule : testbench
